// ### bench/tb_aux_ilock_ctrl.sv
// Purpose: self-checking bench for the interlocked auxiliary outputs
// Assumes: 25 MHz clock, register port answers one cycle after a read
// Notes: each pin change is given eight cycles to pass the synchroniser
`timescale 1ns/10ps
module tb_aux_ilock_ctrl;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] reg_rdata;
	logic key, sw1, sw2, park, door, pto, eng, mov, aux_out1, aux_out2;
	logic [7:0] speed, gear, cur1, cur2, rv;
	logic [4:0] c;
	logic [7:0] sp, gr;
	int n_mismatch = 0;
	int n_tests = 0;
	always #20 clk_sys = ~clk_sys;
	vehicle_model u_veh (.clk_sys(clk_sys), .key_on_pin(key), .switch1_pin(sw1),
		.switch2_pin(sw2), .park_brake_pin(park), .door_open_pin(door),
		.pto_engaged_pin(pto), .engine_running_pin(eng), .vehicle_moving_pin(mov),
		.vehicle_speed(speed), .gear_code(gear), .load_current_out1(cur1),
		.load_current_out2(cur2));
	aux_ilock_ctrl u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .key_on_pin(key), .switch1_pin(sw1), .switch2_pin(sw2),
		.park_brake_pin(park), .door_open_pin(door), .pto_engaged_pin(pto),
		.engine_running_pin(eng), .vehicle_moving_pin(mov), .vehicle_speed(speed),
		.gear_code(gear), .load_current_out1(cur1), .load_current_out2(cur2),
		.aux_out1(aux_out1), .aux_out2(aux_out2));
	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic settle;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	// pins and data that make selection s true or false
	task automatic cond(input logic [4:0] s, input logic t);
		logic lv;
		lv = s[0] ? t : !t;
		c = 5'h00;
		sp = 8'h00;
		gr = 8'h00;
		case (s)
			5'h01, 5'h02: c[4] = lv;
			5'h03, 5'h04: c[3] = lv;
			5'h05, 5'h06: c[2] = lv;
			5'h07, 5'h08: c[1] = lv;
			5'h0b, 5'h0c: c[0] = !lv;
			5'h09: sp = t ? 8'h1f : 8'h1e;
			5'h0a: sp = t ? 8'h1d : 8'h1e;
			5'h0d: gr = t ? 8'h7e : 8'h7d;
			5'h0e: gr = t ? 8'h7c : 8'h7d;
			5'h0f: gr = t ? 8'h7d : 8'h7e;
			5'h10: gr = t ? 8'h7e : 8'h7d;
			default: c = 5'h00;
		endcase
	endtask
	task automatic summarize;
		$display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watchdog well beyond the expected run of about 700 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		summarize();
	end
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		logic [4:0] s;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(aux_ilock_pkg::REG_SEL, rv); check(rv, 8'h0a);
		rd(aux_ilock_pkg::REG_LATCH, rv); check(rv, 8'h00);
		rd(aux_ilock_pkg::REG_SPEED, rv); check(rv, 8'h1e);
		rd(aux_ilock_pkg::REG_FUSE, rv); check(rv, 8'hc8);
		rd(4'hb, rv); check(rv, 8'h00);
		wr(aux_ilock_pkg::REG_SPEED, 8'hc8);
		rd(aux_ilock_pkg::REG_SPEED, rv); check(rv, 8'h64);
		wr(aux_ilock_pkg::REG_SPEED, 8'h1e);
		$display("test reset values done");
		wr(aux_ilock_pkg::REG_GEAR, 8'h7d);
		wr(aux_ilock_pkg::CH_STRIDE + aux_ilock_pkg::REG_SEL, 8'h00);
		for (int i = 0; i < 18; i++) begin
			s = 5'(i);
			wr(aux_ilock_pkg::REG_SEL, {3'h0, s});
			for (int k = 1; k >= 0; k--) begin
				cond(s, k[0]);
				u_veh.put_pins({3'b111, c});
				u_veh.put_data(sp, gr, 8'h00, 8'h00);
				settle();
				check({7'h0, aux_out1},
					{7'h0, (s == 5'h00 || s > 5'h10) | k[0]});
				check({7'h0, aux_out2}, 8'h01);
			end
		end
		$display("test selection table done");
		wr(aux_ilock_pkg::REG_SEL, 8'h01);
		wr(aux_ilock_pkg::REG_LATCH, 8'h01);
		u_veh.put_pins(8'hf0); settle(); check({7'h0, aux_out1}, 8'h01);
		u_veh.put_pins(8'he0); settle(); check({7'h0, aux_out1}, 8'h00);
		u_veh.put_pins(8'hf0); settle(); check({7'h0, aux_out1}, 8'h00);
		rd(aux_ilock_pkg::REG_STATUS, rv); check(rv, 8'h0a);
		u_veh.put_pins(8'hb0); settle(); check({7'h0, aux_out1}, 8'h00);
		u_veh.put_pins(8'hf0); settle(); check({7'h0, aux_out1}, 8'h01);
		u_veh.put_data(8'h1f, 8'h00, 8'h00, 8'h00); wr(aux_ilock_pkg::REG_SEL, 8'h09);
		u_veh.put_data(8'h1e, 8'h00, 8'h00, 8'h00);
		u_veh.put_data(8'h1f, 8'h00, 8'h00, 8'h00);
		settle(); check({7'h0, aux_out1}, 8'h00);
		u_veh.put_pins(8'hb0); @(posedge clk_sys); u_veh.put_pins(8'hf0);
		settle(); check({7'h0, aux_out1}, 8'h01);
		wr(aux_ilock_pkg::REG_SEL, 8'h01);
		$display("test latch-off done");
		wr(aux_ilock_pkg::REG_LATCH, 8'h00);
		u_veh.put_pins(8'he0); settle(); check({7'h0, aux_out1}, 8'h00);
		u_veh.put_pins(8'hf0); settle(); check({7'h0, aux_out1}, 8'h01);
		wr(aux_ilock_pkg::REG_SEL, 8'h00);
		wr(aux_ilock_pkg::REG_FUSE, 8'h05);
		rd(aux_ilock_pkg::REG_FUSE, rv); check(rv, 8'h0a);
		u_veh.put_data(8'h00, 8'h00, 8'h09, 8'h00); settle();
		check({7'h0, aux_out1}, 8'h01);
		u_veh.put_data(8'h00, 8'h00, 8'h0a, 8'h00); settle();
		check({7'h0, aux_out1}, 8'h00);
		rd(aux_ilock_pkg::REG_STATUS, rv); check(rv, 8'h0c);
		u_veh.put_data(8'h00, 8'h00, 8'h00, 8'h00);
		u_veh.put_pins(8'hb0); settle();
		u_veh.put_pins(8'hf0); settle(); check({7'h0, aux_out1}, 8'h01);
		wr(aux_ilock_pkg::CH_STRIDE + aux_ilock_pkg::REG_SEL, 8'h01);
		u_veh.put_pins(8'he0); settle();
		check({6'h0, aux_out2, aux_out1}, 8'h01);
		wr(aux_ilock_pkg::CH_STRIDE + aux_ilock_pkg::REG_SEL, 8'h00);
		u_veh.put_data(8'h20, 8'h7d, 8'h00, 8'hc8); settle();
		rd(aux_ilock_pkg::REG_STATUS, rv); check(rv, 8'h21);
		u_veh.put_data(8'h00, 8'h00, 8'h00, 8'h00);
		u_veh.put_pins(8'hd0); settle();
		check({6'h0, aux_out2, aux_out1}, 8'h01);
		u_veh.put_pins(8'hf0); settle();
		check({6'h0, aux_out2, aux_out1}, 8'h03);
		$display("test current limit done");
		@(posedge clk_sys);
		clk_en <= 1'b0;
		u_veh.put_pins(8'h70); settle();
		check({6'h0, aux_out2, aux_out1}, 8'h03);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		settle();
		check({6'h0, aux_out2, aux_out1}, 8'h00);
		$display("test key off done");
		summarize();
	end
endmodule

// ### bench/vehicle_model.sv
// Purpose: vehicle side model: rocker switches, status pins and vehicle data
// Assumes: every level changes just after a rising clock edge
// Notes: levels hold until the bench asks for a new set
`timescale 1ns/10ps
module vehicle_model (
	input wire logic clk_sys,
	output logic key_on_pin,
	output logic switch1_pin,
	output logic switch2_pin,
	output logic park_brake_pin,
	output logic door_open_pin,
	output logic pto_engaged_pin,
	output logic engine_running_pin,
	output logic vehicle_moving_pin,
	output logic [7:0] vehicle_speed,
	output logic [7:0] gear_code,
	output logic [7:0] load_current_out1,
	output logic [7:0] load_current_out2
);
	// everything off and still at power up
	initial begin
		{key_on_pin, switch1_pin, switch2_pin, park_brake_pin} = 4'h0;
		{door_open_pin, pto_engaged_pin, engine_running_pin, vehicle_moving_pin} = 4'h0;
		{vehicle_speed, gear_code, load_current_out1, load_current_out2} = 32'h0;
	end
	// pin set: key, switch1, switch2, park, door, pto, engine, moving
	task automatic put_pins(input logic [7:0] p);
		@(posedge clk_sys);
		{key_on_pin, switch1_pin, switch2_pin, park_brake_pin} <= p[7:4];
		{door_open_pin, pto_engaged_pin, engine_running_pin, vehicle_moving_pin} <= p[3:0];
	endtask
	// same-clock vehicle data
	task automatic put_data(input logic [7:0] sp, input logic [7:0] gr,
		input logic [7:0] c1, input logic [7:0] c2);
		@(posedge clk_sys);
		{vehicle_speed, gear_code, load_current_out1, load_current_out2} <= {sp, gr, c1, c2};
	endtask
endmodule

// ### hdl/aux_ilock_ctrl.sv
// Purpose: two independent switch-driven auxiliary outputs with interlocks
// Assumes: vehicle speed, gear code and load currents come from same-clock logic
// Notes: discrete vehicle pins and switches pass a three-stage synchroniser
`timescale 1ns/10ps
module aux_ilock_ctrl (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [aux_ilock_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [aux_ilock_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [aux_ilock_pkg::DATA_W-1:0] reg_rdata,
	input wire logic key_on_pin,
	input wire logic switch1_pin,
	input wire logic switch2_pin,
	input wire logic park_brake_pin,
	input wire logic door_open_pin,
	input wire logic pto_engaged_pin,
	input wire logic engine_running_pin,
	input wire logic vehicle_moving_pin,
	input wire logic [aux_ilock_pkg::DATA_W-1:0] vehicle_speed,
	input wire logic [aux_ilock_pkg::DATA_W-1:0] gear_code,
	input wire logic [aux_ilock_pkg::DATA_W-1:0] load_current_out1,
	input wire logic [aux_ilock_pkg::DATA_W-1:0] load_current_out2,
	output logic aux_out1,
	output logic aux_out2
);
	localparam int N = aux_ilock_pkg::NUM_OUT;

	// -----------------------------------------------------------------
	// helper functions
	// -----------------------------------------------------------------

	// address of a per-output register
	function automatic logic reg_hit(
		input logic [aux_ilock_pkg::ADDR_W-1:0] a,
		input int ch,
		input logic [aux_ilock_pkg::ADDR_W-1:0] idx
	);
		logic [aux_ilock_pkg::ADDR_W-1:0] base;
		base = aux_ilock_pkg::CH_STRIDE * aux_ilock_pkg::ADDR_W'(ch);
		return a == (base + idx);
	endfunction

	// keep a written value inside its allowed range
	function automatic logic [aux_ilock_pkg::DATA_W-1:0] clamp(
		input logic [aux_ilock_pkg::DATA_W-1:0] v,
		input logic [aux_ilock_pkg::DATA_W-1:0] lo,
		input logic [aux_ilock_pkg::DATA_W-1:0] hi
	);
		if (v < lo) begin
			return lo;
		end
		if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// -----------------------------------------------------------------
	// input synchronisation
	// -----------------------------------------------------------------
	logic [aux_ilock_pkg::NUM_PINS-1:0] pins_raw;
	logic [aux_ilock_pkg::NUM_PINS-1:0] pins_s;
	logic key_s;
	logic sw_s [N];
	logic [aux_ilock_pkg::DATA_W-1:0] cur [N];

	// all discrete pins gathered for one synchroniser
	assign pins_raw = {vehicle_moving_pin, engine_running_pin, pto_engaged_pin,
		door_open_pin, park_brake_pin, switch2_pin, switch1_pin, key_on_pin};

	in_sync #(
		.W(aux_ilock_pkg::NUM_PINS)
	) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.pin_in(pins_raw),
		.level_out(pins_s)
	);

	// per-output view of switch and current
	assign key_s = pins_s[aux_ilock_pkg::PIN_KEY];
	assign sw_s[0] = pins_s[aux_ilock_pkg::PIN_SW0];
	assign sw_s[1] = pins_s[aux_ilock_pkg::PIN_SW0 + 1];
	assign cur[0] = load_current_out1;
	assign cur[1] = load_current_out2;

	// -----------------------------------------------------------------
	// settings registers
	// -----------------------------------------------------------------
	logic [aux_ilock_pkg::SEL_W-1:0] sel_q [N];
	logic latch_q [N];
	logic [aux_ilock_pkg::SPEED_W-1:0] speed_thr_q [N];
	logic [aux_ilock_pkg::DATA_W-1:0] gear_thr_q [N];
	logic [aux_ilock_pkg::DATA_W-1:0] fuse_q [N];
	logic [aux_ilock_pkg::DATA_W-1:0] speed_w;

	// speed writes limited to the documented range
	assign speed_w = clamp(reg_wdata, aux_ilock_pkg::SPEED_MIN, aux_ilock_pkg::SPEED_MAX);

	// software writes, each output with its own set
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < N; i++) begin
				sel_q[i] <= aux_ilock_pkg::SEL_RST;
				latch_q[i] <= 1'b0; // see [R19]
				speed_thr_q[i] <= aux_ilock_pkg::SPEED_RST; // see [R19]
				gear_thr_q[i] <= aux_ilock_pkg::GEAR_RST;
				fuse_q[i] <= aux_ilock_pkg::FUSE_RST;
			end
		end else if (clk_en && reg_wr) begin
			for (int i = 0; i < N; i++) begin // see [R17]
				if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_SEL)) begin
					sel_q[i] <= reg_wdata[aux_ilock_pkg::SEL_W-1:0];
				end
				if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_LATCH)) begin
					latch_q[i] <= reg_wdata[0];
				end
				if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_SPEED)) begin
					speed_thr_q[i] <= speed_w[aux_ilock_pkg::SPEED_W-1:0]; // see [R19]
				end
				if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_GEAR)) begin
					gear_thr_q[i] <= reg_wdata;
				end
				if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_FUSE)) begin
					fuse_q[i] <= clamp(reg_wdata, aux_ilock_pkg::FUSE_MIN,
						aux_ilock_pkg::FUSE_MAX); // see [R16]
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// interlock conditions
	// -----------------------------------------------------------------
	logic cond_ok [N];

	for (genvar g = 0; g < N; g++) begin : g_cond
		ilock_cond u_cond (
			.sel(sel_q[g]),
			.park_brake(pins_s[aux_ilock_pkg::PIN_PARK]),
			.door_open(pins_s[aux_ilock_pkg::PIN_DOOR]),
			.pto_engaged(pins_s[aux_ilock_pkg::PIN_PTO]),
			.engine_running(pins_s[aux_ilock_pkg::PIN_ENGINE]),
			.vehicle_moving(pins_s[aux_ilock_pkg::PIN_MOVING]),
			.speed(vehicle_speed),
			.speed_thr(speed_thr_q[g]),
			.gear(gear_code),
			.gear_thr(gear_thr_q[g]),
			.cond_ok(cond_ok[g])
		);
	end

	// -----------------------------------------------------------------
	// output state machines
	// -----------------------------------------------------------------
	aux_ilock_pkg::chan_state_t st_q [N];
	aux_ilock_pkg::chan_state_t st_d [N];
	logic trip_q [N];
	logic out_q [N];
	logic over [N];
	logic permit [N];

	// next state; a latched output waits for the switch to go off
	always_comb begin
		for (int i = 0; i < N; i++) begin
			over[i] = cur[i] >= fuse_q[i]; // see [R16]
			permit[i] = key_s && cond_ok[i] && !over[i] && !trip_q[i]; // see [R18]
			st_d[i] = st_q[i];
			case (st_q[i])
				aux_ilock_pkg::ST_OFF: begin
					if (sw_s[i] && permit[i]) begin // see [R1] [R10] [R12]
						st_d[i] = aux_ilock_pkg::ST_ON;
					end
				end
				aux_ilock_pkg::ST_ON: begin
					if (!sw_s[i] || over[i] || !key_s) begin // see [R16] [R18]
						st_d[i] = aux_ilock_pkg::ST_OFF;
					end else if (!cond_ok[i]) begin
						st_d[i] = latch_q[i] ? aux_ilock_pkg::ST_LATCHED // see [R11]
							: aux_ilock_pkg::ST_OFF; // see [R10]
					end
				end
				aux_ilock_pkg::ST_LATCHED: begin
					if (!sw_s[i]) begin // see [R12]
						st_d[i] = aux_ilock_pkg::ST_OFF;
					end
				end
				default: st_d[i] = aux_ilock_pkg::ST_OFF;
			endcase
		end
	end

	// state and registered output drive
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < N; i++) begin
				st_q[i] <= aux_ilock_pkg::ST_OFF;
				out_q[i] <= 1'b0;
			end
		end else if (clk_en) begin
			for (int i = 0; i < N; i++) begin
				st_q[i] <= st_d[i];
				out_q[i] <= st_d[i] == aux_ilock_pkg::ST_ON;
			end
		end
	end

	// over-current trip holds until the switch is turned off
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < N; i++) begin
				trip_q[i] <= 1'b0;
			end
		end else if (clk_en) begin
			for (int i = 0; i < N; i++) begin
				if (st_q[i] == aux_ilock_pkg::ST_ON && over[i]) begin // see [R16]
					trip_q[i] <= 1'b1;
				end else if (!sw_s[i]) begin
					trip_q[i] <= 1'b0;
				end
			end
		end
	end

	assign aux_out1 = out_q[0];
	assign aux_out2 = out_q[1];

	// -----------------------------------------------------------------
	// register read port
	// -----------------------------------------------------------------
	logic [aux_ilock_pkg::DATA_W-1:0] rd_mux;
	logic [aux_ilock_pkg::DATA_W-1:0] rdata_q;

	// read selection; unmapped addresses read zero
	always_comb begin
		rd_mux = '0;
		for (int i = 0; i < N; i++) begin
			if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_SEL)) begin
				rd_mux = {3'h0, sel_q[i]};
			end
			if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_LATCH)) begin
				rd_mux = {7'h00, latch_q[i]};
			end
			if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_SPEED)) begin
				rd_mux = {1'b0, speed_thr_q[i]};
			end
			if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_GEAR)) begin
				rd_mux = gear_thr_q[i];
			end
			if (reg_hit(reg_addr, i, aux_ilock_pkg::REG_FUSE)) begin
				rd_mux = fuse_q[i];
			end
		end
		if (reg_addr == aux_ilock_pkg::REG_STATUS) begin
			for (int i = 0; i < N; i++) begin
				rd_mux[i*aux_ilock_pkg::ST_CH_W + aux_ilock_pkg::ST_OUT] = out_q[i];
				rd_mux[i*aux_ilock_pkg::ST_CH_W + aux_ilock_pkg::ST_LOCK] =
					st_q[i] == aux_ilock_pkg::ST_LATCHED;
				rd_mux[i*aux_ilock_pkg::ST_CH_W + aux_ilock_pkg::ST_TRIP] = trip_q[i];
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= '0;
		end else if (clk_en) begin
			rdata_q <= reg_rd ? rd_mux : '0;
		end
	end

	assign reg_rdata = rdata_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n || !clk_en);

	// latched drop, then the switch stays on with the condition back
	sequence s_latched_drop;
		out_q[0] && latch_q[0] && sw_s[0] && key_s && !cond_ok[0] && !over[0]
		##1 sw_s[0] && permit[0];
	endsequence

	// latched output sees switch off for two cycles, the shortest the filter passes,
	// then switch on with permission
	sequence s_recycle;
		st_q[0] == aux_ilock_pkg::ST_LATCHED && !sw_s[0]
		##1 !sw_s[0] ##1 sw_s[0] && permit[0];
	endsequence

	chk_out_needs_key: assert property ($rose(out_q[0]) |-> $past(key_s)) // see [R18]
		else $error("output rose without key on");
	chk_no_ilock_follow: assert property ( // see [R1]
		sel_q[0] == aux_ilock_pkg::SEL_NONE && sw_s[0] && key_s && !over[0]
		&& !trip_q[0] && st_q[0] != aux_ilock_pkg::ST_LATCHED |=> out_q[0])
		else $error("selection zero did not follow switch");
	chk_park_gate: assert property ( // see [R2]
		sel_q[0] == aux_ilock_pkg::SEL_PARK_SET && !pins_s[aux_ilock_pkg::PIN_PARK]
		|=> !out_q[0])
		else $error("output on with park brake released");
	chk_door_gate: assert property ( // see [R3]
		sel_q[0] == aux_ilock_pkg::SEL_DOOR_SHUT && pins_s[aux_ilock_pkg::PIN_DOOR]
		|=> !out_q[0])
		else $error("output on with a door open");
	chk_speed_gate: assert property ( // see [R6]
		sel_q[0] == aux_ilock_pkg::SEL_SPEED_ABOVE
		&& vehicle_speed <= {1'b0, speed_thr_q[0]} |=> !out_q[0])
		else $error("output on at or below speed threshold");
	chk_gear_gate: assert property ( // see [R8]
		sel_q[0] == aux_ilock_pkg::SEL_GEAR_ABOVE && gear_code <= gear_thr_q[0]
		|=> !out_q[0])
		else $error("output on at or below gear threshold");
	chk_neutral_gate: assert property ( // see [R9]
		sel_q[0] == aux_ilock_pkg::SEL_NEUTRAL && gear_code != aux_ilock_pkg::GEAR_NEUTRAL
		|=> !out_q[0])
		else $error("output on outside neutral");
	chk_auto_return: assert property ( // see [R10]
		!latch_q[0] && st_q[0] == aux_ilock_pkg::ST_OFF && sw_s[0] && permit[0]
		|=> out_q[0])
		else $error("output did not return with condition");
	chk_latch_hold: assert property (s_latched_drop |=> !out_q[0]) // see [R11]
		else $error("latched output came back without recycle");
	chk_recycle_on: assert property (s_recycle |=> out_q[0]) // see [R12]
		else $error("recycled switch did not restore output");
	chk_fuse_trip: assert property ( // see [R16]
		out_q[0] && cur[0] >= fuse_q[0] |=> !out_q[0] [*2])
		else $error("output stayed on over current limit");
	chk_speed_range: assert property ({1'b0, speed_thr_q[0]} <= aux_ilock_pkg::SPEED_MAX) // see [R19]
		else $error("speed threshold out of range");
	chk_out2_gate: assert property ( // see [R17]
		sel_q[1] == aux_ilock_pkg::SEL_PARK_SET && !pins_s[aux_ilock_pkg::PIN_PARK]
		|=> !out_q[1])
		else $error("second output on with park brake released");
	chk_key_drop: assert property (!key_s |=> !out_q[0] && !out_q[1]) // see [R18]
		else $error("output on with key off");
endmodule

// ### hdl/aux_ilock_pkg.sv
// Purpose: shared constants and types for the interlocked auxiliary output controller
// Assumes: one 25 MHz clock, registers reached over a plain strobe port
// Notes: current figures are in tenths of an ampere, speeds in miles per hour
// Operation
// [R1] selection zero drives the output straight from the rocker switch
// [R2] selection 1 needs park brake set, 2 needs it released, switch on
// [R3] selection 3 needs a door open, 4 needs all doors closed, switch on
// [R4] selection 5 needs power take-off engaged, 6 disengaged, switch on
// [R5] selection 7 needs engine running, 8 engine stopped, switch on
// [R6] selection 9 needs speed above threshold, 10 below it, switch on
// [R7] selection 11 needs vehicle stationary, 12 moving, switch on
// [R8] selection 13 needs gear code above threshold, 14 below it
// [R9] selection 15 needs neutral, 16 needs not neutral, switch on
// [R10] without latch-off the output returns when the condition returns
// [R11] with latch-off an interlock drop keeps the output off
// [R12] a latched output returns only after switch off then on
// [R13] speed threshold is used only for selections 9 and 10
// [R14] gear code 125 is neutral, above forward gears, below reverse gears
// [R15] gear threshold is used only for selections 13 and 14
// [R16] output turns off when load current reaches the limit of 1 to 20 A
// [R17] second output has its own independent selection and settings
// [R18] outputs are powered only with key in ignition or accessory
// [R19] speed threshold resets to 30, range 0 to 100; latch-off resets off
// [R20] inputs are sampled each clock; selection above 16 means no interlock
package aux_ilock_pkg;
	localparam int NUM_OUT = 2;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int SEL_W = 5;
	localparam int SPEED_W = 7;
	localparam int NUM_PINS = 8;

	// -----------------------------------------------------------------
	// synchronised pin positions
	// -----------------------------------------------------------------
	localparam int PIN_KEY = 0;
	localparam int PIN_SW0 = 1;
	localparam int PIN_PARK = 3;
	localparam int PIN_DOOR = 4;
	localparam int PIN_PTO = 5;
	localparam int PIN_ENGINE = 6;
	localparam int PIN_MOVING = 7;

	// -----------------------------------------------------------------
	// condition selections
	// -----------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_NONE = 5'h00;
	localparam logic [SEL_W-1:0] SEL_PARK_SET = 5'h01;
	localparam logic [SEL_W-1:0] SEL_PARK_CLR = 5'h02;
	localparam logic [SEL_W-1:0] SEL_DOOR_OPEN = 5'h03;
	localparam logic [SEL_W-1:0] SEL_DOOR_SHUT = 5'h04;
	localparam logic [SEL_W-1:0] SEL_PTO_ON = 5'h05;
	localparam logic [SEL_W-1:0] SEL_PTO_OFF = 5'h06;
	localparam logic [SEL_W-1:0] SEL_ENG_RUN = 5'h07;
	localparam logic [SEL_W-1:0] SEL_ENG_STOP = 5'h08;
	localparam logic [SEL_W-1:0] SEL_SPEED_ABOVE = 5'h09;
	localparam logic [SEL_W-1:0] SEL_SPEED_BELOW = 5'h0a;
	localparam logic [SEL_W-1:0] SEL_STOPPED = 5'h0b;
	localparam logic [SEL_W-1:0] SEL_MOVING = 5'h0c;
	localparam logic [SEL_W-1:0] SEL_GEAR_ABOVE = 5'h0d;
	localparam logic [SEL_W-1:0] SEL_GEAR_BELOW = 5'h0e;
	localparam logic [SEL_W-1:0] SEL_NEUTRAL = 5'h0f;
	localparam logic [SEL_W-1:0] SEL_NOT_NEUTRAL = 5'h10;
	localparam logic [DATA_W-1:0] GEAR_NEUTRAL = 8'h7d;

	// -----------------------------------------------------------------
	// reset values and limits
	// -----------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_RST = 5'h0a;
	localparam logic [SPEED_W-1:0] SPEED_RST = 7'h1e;
	localparam logic [DATA_W-1:0] SPEED_MIN = 8'h00;
	localparam logic [DATA_W-1:0] SPEED_MAX = 8'h64;
	localparam logic [DATA_W-1:0] GEAR_RST = 8'h00;
	localparam logic [DATA_W-1:0] FUSE_RST = 8'hc8;
	localparam logic [DATA_W-1:0] FUSE_MIN = 8'h0a;
	localparam logic [DATA_W-1:0] FUSE_MAX = 8'hc8;

	// -----------------------------------------------------------------
	// register map: five per output, then one status register
	// -----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_SEL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_LATCH = 4'h1;
	localparam logic [ADDR_W-1:0] REG_SPEED = 4'h2;
	localparam logic [ADDR_W-1:0] REG_GEAR = 4'h3;
	localparam logic [ADDR_W-1:0] REG_FUSE = 4'h4;
	localparam logic [ADDR_W-1:0] CH_STRIDE = 4'h5;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'ha;
	localparam int ST_OUT = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_TRIP = 2;
	localparam int ST_CH_W = 3;

	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_ON = 3'b010,
		ST_LATCHED = 3'b100
	} chan_state_t;
endpackage

// ### hdl/ilock_cond.sv
// Purpose: evaluates one output's interlocking condition
// Assumes: all inputs already synchronous to the system clock
// Notes: purely combinational; the caller registers the result
`timescale 1ns/10ps
module ilock_cond (
	input wire logic [aux_ilock_pkg::SEL_W-1:0] sel,
	input wire logic park_brake,
	input wire logic door_open,
	input wire logic pto_engaged,
	input wire logic engine_running,
	input wire logic vehicle_moving,
	input wire logic [aux_ilock_pkg::DATA_W-1:0] speed,
	input wire logic [aux_ilock_pkg::SPEED_W-1:0] speed_thr,
	input wire logic [aux_ilock_pkg::DATA_W-1:0] gear,
	input wire logic [aux_ilock_pkg::DATA_W-1:0] gear_thr,
	output logic cond_ok
);
	// selection decode; thresholds only reach their own selections
	always_comb begin
		case (sel)
			aux_ilock_pkg::SEL_NONE: cond_ok = 1'b1; // see [R1]
			aux_ilock_pkg::SEL_PARK_SET: cond_ok = park_brake; // see [R2]
			aux_ilock_pkg::SEL_PARK_CLR: cond_ok = !park_brake; // see [R2]
			aux_ilock_pkg::SEL_DOOR_OPEN: cond_ok = door_open; // see [R3]
			aux_ilock_pkg::SEL_DOOR_SHUT: cond_ok = !door_open; // see [R3]
			aux_ilock_pkg::SEL_PTO_ON: cond_ok = pto_engaged; // see [R4]
			aux_ilock_pkg::SEL_PTO_OFF: cond_ok = !pto_engaged; // see [R4]
			aux_ilock_pkg::SEL_ENG_RUN: cond_ok = engine_running; // see [R5]
			aux_ilock_pkg::SEL_ENG_STOP: cond_ok = !engine_running; // see [R5]
			aux_ilock_pkg::SEL_SPEED_ABOVE: cond_ok = speed > {1'b0, speed_thr}; // see [R6] [R13]
			aux_ilock_pkg::SEL_SPEED_BELOW: cond_ok = speed < {1'b0, speed_thr}; // see [R6] [R13]
			aux_ilock_pkg::SEL_STOPPED: cond_ok = !vehicle_moving; // see [R7]
			aux_ilock_pkg::SEL_MOVING: cond_ok = vehicle_moving; // see [R7]
			aux_ilock_pkg::SEL_GEAR_ABOVE: cond_ok = gear > gear_thr; // see [R8] [R15]
			aux_ilock_pkg::SEL_GEAR_BELOW: cond_ok = gear < gear_thr; // see [R8] [R15]
			aux_ilock_pkg::SEL_NEUTRAL: cond_ok = gear == aux_ilock_pkg::GEAR_NEUTRAL; // see [R9] [R14]
			aux_ilock_pkg::SEL_NOT_NEUTRAL: cond_ok = gear != aux_ilock_pkg::GEAR_NEUTRAL; // see [R9]
			default: cond_ok = 1'b1; // see [R20]
		endcase
	end
endmodule

// ### hdl/in_sync.sv
// Purpose: three-stage synchroniser for asynchronous pins
// Assumes: pins change slowly against the clock
// Notes: a change is taken once the second and third stage agree
`timescale 1ns/10ps
module in_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] mid_q;
	logic [W-1:0] late_q;
	logic [W-1:0] level_q;
	logic [W-1:0] agree;

	// bits whose last two stages match
	assign agree = ~(mid_q ^ late_q);

	// shift chain and filtered level
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			mid_q <= '0;
			late_q <= '0;
			level_q <= '0;
		end else if (clk_en) begin
			meta_q <= pin_in;
			mid_q <= meta_q;
			late_q <= mid_q;
			level_q <= (late_q & agree) | (level_q & ~agree);
		end
	end

	assign level_out = level_q;
endmodule
